// *** logic/imr_pkg.sv ***
// Shared constants, field layouts, opcodes and state types of the interval readout link.
// Notes on behaviour
// - Read opcode shifts result MSB first; SCK clears interrupt.
// - Uncalibrated result is 16-bit signed bin count.
// - Calibrated result is 32-bit signed reference periods.
// - Calculation overflow writes all ones.
// - One hit per selector write; host waits.
// - Init opcode needed before next measurement.
// - One start, one stop channel, three stops.
// - Fine from edges to reference tick; coarse between.
// - Coarse counter spans 2^14 divided periods.
// - Edges at least two divided periods apart.
// - Too short intervals are discarded, never wrong.
// - Start and stop have own inversion bits.
// - Inputs accepted only while enable high.
// - Config 0 bit 11 selects extended range.
// - Oscillator switch-on field: on, ceramic, quartz.
// - Predivider 1, 2 or 4 scales period.
// - Two periods not below 2.4 us overflow.
// - Divided reference must be 2 to 8 MHz; predivider 4 gives 1 MHz here.
// - Expected hits A is stops plus one; B zero.
// - Calibration measures one and two periods.
// - Calibrate by opcode or automatically after measurement.
// - Two selectors pick hits; coarse plus scaled fine.
// - Result sets interrupt and bumps load pointer.
package imr_pkg;
	localparam int CLK_MHZ = 100;
	localparam logic [7:0] OP_MASK = 8'hF8;
	localparam logic [7:0] OP_READ = 8'hB0;
	localparam logic [7:0] OP_WRITE = 8'h80;
	localparam logic [7:0] OP_INIT = 8'h70;
	localparam logic [7:0] OP_CAL = 8'h03;
	localparam logic [2:0] STATUS_ADR = 3'h4;
	localparam logic [2:0] CFG_HIT_ADR = 3'h1;
	localparam logic [2:0] CFG_LAST_ADR = 3'h2;
	localparam logic [5:0] BC_OP_LAST = 6'h07;
	localparam logic [5:0] BC_OP_BITS = 6'h08;
	localparam logic [5:0] BC_WR_LAST = 6'h27;
	localparam logic [5:0] BC_MAX = 6'h3F;
	localparam int F_START_INV = 0;
	localparam int F_STOP_INV = 1;
	localparam int F_EXT_RANGE = 11;
	localparam int F_NO_AUTO_CAL = 12;
	localparam int F_CALIBRATE = 13;
	localparam int F_OSC_LO = 18;
	localparam int F_DIV_LO = 20;
	localparam int F_HITS_A_LO = 16;
	localparam int F_HITS_B_LO = 19;
	localparam int F_SEL_M_LO = 24;
	localparam int F_SEL_S_LO = 28;
	localparam int F_ALU_IRQ_EN = 29;
	localparam logic [31:0] CFG_RST = 32'h0000_0000;
	localparam logic [31:0] ALL_ONES = 32'hFFFF_FFFF;
	localparam logic [3:0] SEL_START = 4'h1;
	localparam logic [3:0] SEL_STOP3 = 4'h4;
	localparam logic [3:0] SEL_OFF = 4'h5;
	localparam logic [3:0] SEL_ONE_PERIOD_CAL_COUNT = 4'h6;
	localparam logic [3:0] SEL_TWO_PERIOD_CAL_COUNT = 4'h7;
	localparam logic [2:0] HITS_MIN = 3'h2;
	localparam logic [2:0] HITS_MAX = 3'h4;
	localparam logic [1:0] OSC_ON = 2'h1;
	localparam logic [1:0] OSC_QUARTZ = 2'h3;
	localparam int COARSE_W = 14;
	localparam int FINE_W = 8;
	localparam int CAL_W = 9;
	localparam int FRAC_BITS = 16;
	localparam logic [COARSE_W-1:0] MIN_SPACING = 14'h0002;
	localparam logic [FINE_W-1:0] REF_BASE_CYC = 8'h19;
	localparam int CAL_LIMIT_NS = 2400;
	localparam int CAL_LIMIT_CYC = CAL_LIMIT_NS * CLK_MHZ / 1000;
	localparam int ALU_TIME_NS = 4600;
	localparam int ALU_CYC = (ALU_TIME_NS * CLK_MHZ + 999) / 1000;
	localparam int HIT_WAIT_NS = 4600;
	localparam int HIT_WAIT_CYC = (HIT_WAIT_NS * CLK_MHZ + 999) / 1000;
	localparam int SLOW_HZ = 32768;
	localparam int SLOW_DIV_CYC = CLK_MHZ * 1000000 / SLOW_HZ;
	localparam logic [5:0] WARM_CERAMIC = 6'h04;
	localparam logic [5:0] WARM_QUARTZ = 6'h20;
	localparam logic [3:0] SCK_HALF_CYC = 4'h8;
	localparam logic [11:0] A_CTRL = 12'h000;
	localparam logic [11:0] A_TX = 12'h004;
	localparam logic [11:0] A_RX = 12'h008;
	localparam logic [11:0] A_STAT = 12'h00C;
	localparam int C_LEN_LO = 8;
	localparam int C_GO = 31;
	typedef enum logic [2:0] {
		M_IDLE = 3'b000, M_ARMED = 3'b001, M_RUN = 3'b011,
		M_CAL = 3'b010, M_ALU = 3'b110, M_DONE = 3'b111
	} imr_meas_t;
	typedef enum logic [1:0] {
		H_IDLE = 2'b00, H_LEAD = 2'b01, H_SHIFT = 2'b11, H_GUARD = 2'b10
	} imr_host_t;
endpackage : imr_pkg

// *** logic/imr_link_if.sv ***
// Serial command link between host controller and measurement device.
`timescale 1ns/100ps
interface imr_link_if;
	logic sck;
	logic sel_n;
	logic mosi;
	logic miso;
	logic irq_out_n;
	modport host (output sck, output sel_n, output mosi, input miso, input irq_out_n);
	modport dev (input sck, input sel_n, input mosi, output miso, output irq_out_n);
endinterface : imr_link_if

// *** logic/imr_device.sv ***
// Device end: serial command port, extended-range interval measurement and result ALU.
//
// Our own choices: the APB interface to the registers and the register offsets.
`timescale 1ns/100ps
module imr_device import imr_pkg::*; (
	input logic clk, // System clock.
	input logic reset_n, // Asynchronous reset, active low.
	imr_link_if.dev link, // Serial port toward the host.
	input logic start_in, // Start pulse pin.
	input logic stop_in, // Stop pulse pin.
	input logic start_en, // Start enable pin, active high.
	input logic stop_en, // Stop enable pin, active high.
	output logic osc_power_on // Fast oscillator power request.
);
	localparam int NPIN = 7;
	localparam int P_SCK = 0;
	localparam int P_SEL = 1;
	localparam int P_MOSI = 2;
	localparam int P_START = 3;
	localparam int P_STOP = 4;
	localparam int P_START_EN = 5;
	localparam int P_STOP_EN = 6;
	logic [NPIN-1:0] pins, meta_r, sync_r, prev_r;
	logic sck_rise, sck_fall, lvl_start, lvl_stop, old_start, old_stop, start_ev, stop_ev;
	logic [31:0] cfg_r [0:2];
	logic [31:0] cfg_nxt [0:2];
	logic [5:0] bit_cnt_r, bit_cnt_nxt;
	logic [31:0] in_sr_r, in_sr_nxt, out_sr_r, out_sr_nxt, rd_word;
	logic [7:0] op_r, op_nxt, op_now;
	logic irq_r, irq_nxt, init_p, cal_p, hit_wr_p, alu_irq_p;
	logic [2:0] rd_idx;
	logic ext_mode, cal_en, no_auto, irq_en, osc_ok, tick, slow_tick, cfg_ok;
	logic [1:0] osc_sel, div_sel;
	logic [2:0] hits_a, hits_b;
	logic [3:0] sel_m, sel_s;
	logic [FINE_W-1:0] per, fine_now;
	imr_meas_t st_r, st_nxt;
	logic [FINE_W-1:0] div_r, div_nxt;
	logic [15:0] slow_r, slow_nxt;
	logic [5:0] warm_r, warm_nxt;
	logic [COARSE_W-1:0] coarse_r, coarse_nxt, last_r, last_nxt;
	logic [COARSE_W-1:0] hc_r [0:3];
	logic [COARSE_W-1:0] hc_nxt [0:3];
	logic [FINE_W-1:0] hf_r [0:3];
	logic [FINE_W-1:0] hf_nxt [0:3];
	logic [2:0] hits_r, hits_nxt, ptr_r, ptr_nxt;
	logic [CAL_W-1:0] one_period_cal_count_r, one_period_cal_count_nxt, two_period_cal_count_r, two_period_cal_count_nxt, ccnt_r, ccnt_nxt;
	logic [1:0] cph_r, cph_nxt;
	logic cal_alu_r, cal_alu_nxt;
	logic [8:0] alu_r, alu_nxt;
	logic [31:0] res_r [0:3];
	logic [31:0] res_nxt [0:3];

	// Synchronisers: every pin passes two flops, edges are taken from the second.
	assign pins = {stop_en, start_en, stop_in, start_in, link.mosi, link.sel_n, link.sck};
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			meta_r <= '1;
			sync_r <= '1;
			prev_r <= '1;
		end else begin
			meta_r <= pins;
			sync_r <= meta_r;
			prev_r <= sync_r;
		end
	end
	assign sck_rise = sync_r[P_SCK] & ~prev_r[P_SCK];
	assign sck_fall = ~sync_r[P_SCK] & prev_r[P_SCK];
	assign lvl_start = sync_r[P_START] ^ cfg_r[0][F_START_INV];
	assign lvl_stop = sync_r[P_STOP] ^ cfg_r[0][F_STOP_INV];
	assign old_start = prev_r[P_START] ^ cfg_r[0][F_START_INV];
	assign old_stop = prev_r[P_STOP] ^ cfg_r[0][F_STOP_INV];
	assign start_ev = lvl_start & ~old_start & sync_r[P_START_EN];
	assign stop_ev = lvl_stop & ~old_stop & sync_r[P_STOP_EN];

	assign ext_mode = cfg_r[0][F_EXT_RANGE];
	assign no_auto = cfg_r[0][F_NO_AUTO_CAL];
	assign cal_en = cfg_r[0][F_CALIBRATE];
	assign osc_sel = cfg_r[0][F_OSC_LO +: 2];
	assign div_sel = (cfg_r[0][F_DIV_LO +: 2] == 2'h3) ? 2'h2 : cfg_r[0][F_DIV_LO +: 2];
	assign hits_a = cfg_r[1][F_HITS_A_LO +: 3];
	assign hits_b = cfg_r[1][F_HITS_B_LO +: 3];
	assign sel_m = cfg_r[1][F_SEL_M_LO +: 4];
	assign sel_s = cfg_r[1][F_SEL_S_LO +: 4];
	assign irq_en = cfg_r[2][F_ALU_IRQ_EN];
	// A start plus one to three stops on channel A only.
	assign cfg_ok = ext_mode && hits_b == 3'h0 && hits_a >= HITS_MIN && hits_a <= HITS_MAX;
	assign per = REF_BASE_CYC << div_sel;
	assign fine_now = per - div_r;
	assign slow_tick = slow_r == 16'(SLOW_DIV_CYC - 1);
	// Switch-on 2 and 3 power the oscillator only while the sequencer is outside M_IDLE and M_DONE.
	assign osc_ok = osc_sel == OSC_ON || (osc_sel[1] && warm_r >= (osc_sel == OSC_QUARTZ ? WARM_QUARTZ : WARM_CERAMIC));
	assign osc_power_on = osc_sel == OSC_ON || (osc_sel[1] && st_r != M_IDLE && st_r != M_DONE);
	assign tick = osc_ok && div_r == per - 8'h01;

	// Serial command port.
	assign op_now = {in_sr_r[6:0], sync_r[P_MOSI]};
	assign rd_idx = op_now[2:0];
	always_comb begin
		if (rd_idx == STATUS_ADR) begin
			rd_word = {7'h00, st_r, hits_r, ptr_r, 16'h0000};
		end else if (rd_idx < STATUS_ADR) begin
			rd_word = cal_en ? res_r[rd_idx[1:0]] : {res_r[rd_idx[1:0]][15:0], 16'h0000};
		end else begin
			rd_word = '0;
		end
	end
	always_comb begin
		bit_cnt_nxt = bit_cnt_r;
		in_sr_nxt = in_sr_r;
		out_sr_nxt = out_sr_r;
		op_nxt = op_r;
		cfg_nxt = cfg_r;
		irq_nxt = irq_r;
		init_p = 1'b0;
		cal_p = 1'b0;
		hit_wr_p = 1'b0;
		if (sck_rise) begin
			irq_nxt = 1'b0;
		end
		if (alu_irq_p) begin
			irq_nxt = 1'b1;
		end
		if (sync_r[P_SEL]) begin
			bit_cnt_nxt = '0;
		end else if (sck_rise) begin
			in_sr_nxt = {in_sr_r[30:0], sync_r[P_MOSI]};
			if (bit_cnt_r != BC_MAX) begin
				bit_cnt_nxt = bit_cnt_r + 6'h01;
			end
			if (bit_cnt_r == BC_OP_LAST) begin
				op_nxt = op_now;
				init_p = op_now == OP_INIT;
				cal_p = op_now == OP_CAL;
				if ((op_now & OP_MASK) == OP_READ) begin
					out_sr_nxt = rd_word;
				end
			end
			if (bit_cnt_r == BC_WR_LAST && (op_r & OP_MASK) == OP_WRITE && op_r[2:0] <= CFG_LAST_ADR) begin
				cfg_nxt[op_r[1:0]] = {in_sr_r[30:0], sync_r[P_MOSI]};
				hit_wr_p = op_r[2:0] == CFG_HIT_ADR;
			end
		end else if (sck_fall && bit_cnt_r > BC_OP_BITS) begin
			out_sr_nxt = {out_sr_r[30:0], 1'b0};
		end
	end
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			bit_cnt_r <= '0;
			in_sr_r <= '0;
			out_sr_r <= '0;
			op_r <= '0;
			cfg_r <= '{default: CFG_RST};
			irq_r <= 1'b0;
		end else begin
			bit_cnt_r <= bit_cnt_nxt;
			in_sr_r <= in_sr_nxt;
			out_sr_r <= out_sr_nxt;
			op_r <= op_nxt;
			cfg_r <= cfg_nxt;
			irq_r <= irq_nxt;
		end
	end
	assign link.miso = out_sr_r[31];
	assign link.irq_out_n = ~irq_r;

	// ALU: one selected hit pair per run.
	function automatic logic [31:0] alu_calc(input logic [3:0] sm, input logic [3:0] ss);
		logic [1:0] a;
		logic [1:0] b;
		logic signed [15:0] dc;
		logic signed [15:0] df;
		logic signed [15:0] unc;
		logic signed [47:0] q;
		logic [CAL_W-1:0] grad;
		a = 2'(sm - SEL_START);
		b = 2'(ss - SEL_START);
		dc = $signed({2'b00, hc_r[a]}) - $signed({2'b00, hc_r[b]});
		df = $signed({8'h00, hf_r[b]}) - $signed({8'h00, hf_r[a]});
		unc = 16'(dc * $signed({8'h00, per}) + df);
		grad = two_period_cal_count_r - one_period_cal_count_r;
		q = (48'(df) <<< FRAC_BITS) / $signed({39'h0, grad});
		if (sm == SEL_ONE_PERIOD_CAL_COUNT) begin
			alu_calc = {23'h0, one_period_cal_count_r};
		end else if (sm == SEL_TWO_PERIOD_CAL_COUNT) begin
			alu_calc = {23'h0, two_period_cal_count_r};
		end else if (sm < SEL_START || sm > SEL_STOP3 || ss < SEL_START || ss > SEL_STOP3 || {1'b0, a} >= hits_r || {1'b0, b} >= hits_r) begin
			alu_calc = ALL_ONES;
		end else if (!cal_en) begin
			alu_calc = {{16{unc[15]}}, unc};
		end else if (two_period_cal_count_r >= CAL_W'(CAL_LIMIT_CYC) || two_period_cal_count_r <= one_period_cal_count_r) begin
			alu_calc = ALL_ONES;
		end else begin
			alu_calc = 32'((48'(dc) <<< FRAC_BITS) + q);
		end
	endfunction : alu_calc

	// Measurement sequencer.
	always_comb begin
		st_nxt = st_r;
		div_nxt = (!osc_ok || tick) ? '0 : div_r + 8'h01;
		slow_nxt = slow_tick ? '0 : slow_r + 16'h0001;
		warm_nxt = warm_r;
		coarse_nxt = coarse_r;
		last_nxt = last_r;
		hc_nxt = hc_r;
		hf_nxt = hf_r;
		hits_nxt = hits_r;
		ptr_nxt = ptr_r;
		one_period_cal_count_nxt = one_period_cal_count_r;
		two_period_cal_count_nxt = two_period_cal_count_r;
		ccnt_nxt = ccnt_r;
		cph_nxt = cph_r;
		cal_alu_nxt = cal_alu_r;
		alu_nxt = alu_r;
		res_nxt = res_r;
		alu_irq_p = 1'b0;
		if (st_r == M_IDLE || st_r == M_DONE) begin
			warm_nxt = '0;
		end else if (slow_tick && warm_r != '1) begin
			warm_nxt = warm_r + 6'h01;
		end
		case (st_r)
			M_ARMED: begin
				if (start_ev && osc_ok) begin
					hc_nxt[0] = '0;
					hf_nxt[0] = fine_now;
					hits_nxt = 3'h1;
					// A tick in the start cycle is already inside the interval, so it counts.
					coarse_nxt = tick ? 14'h0001 : '0;
					last_nxt = '0;
					st_nxt = M_RUN;
				end
			end
			M_RUN: begin
				if (tick) begin
					coarse_nxt = coarse_r + 14'h0001;
				end
				if (stop_ev && hits_r < hits_a && coarse_r - last_r >= MIN_SPACING) begin
					hc_nxt[hits_r[1:0]] = coarse_r;
					hf_nxt[hits_r[1:0]] = fine_now;
					hits_nxt = hits_r + 3'h1;
					last_nxt = coarse_r;
				end
				// Timeout at the end of the coarse span also ends the run.
				if (hits_nxt == hits_a || (tick && coarse_r == '1)) begin
					cal_alu_nxt = 1'b1;
					cph_nxt = '0;
					st_nxt = (cal_en && !no_auto) ? M_CAL : M_ALU;
				end
			end
			M_CAL: begin
				ccnt_nxt = (ccnt_r == '1) ? ccnt_r : ccnt_r + 9'h001;
				if (tick) begin
					cph_nxt = cph_r + 2'h1;
					if (cph_r == 2'h0) begin
						ccnt_nxt = '0;
					end else if (cph_r == 2'h1) begin
						one_period_cal_count_nxt = ccnt_nxt;
					end else begin
						two_period_cal_count_nxt = ccnt_nxt;
						st_nxt = cal_alu_r ? M_ALU : M_IDLE;
					end
				end
			end
			M_ALU: begin
				alu_nxt = alu_r + 9'h001;
				if (alu_r == 9'(ALU_CYC - 1)) begin
					alu_nxt = '0;
					st_nxt = M_DONE;
					if (!(sel_m == SEL_OFF && sel_s == SEL_OFF)) begin
						if (ptr_r < HITS_MAX) begin
							res_nxt[ptr_r[1:0]] = alu_calc(sel_m, sel_s);
						end
						ptr_nxt = ptr_r + 3'h1;
						alu_irq_p = irq_en;
					end
				end
			end
			M_DONE: begin
				if (hit_wr_p) begin
					st_nxt = M_ALU;
				end
			end
			M_IDLE: begin
			end
			default: begin
				st_nxt = M_IDLE;
			end
		endcase
		if (cal_p && (st_r == M_IDLE || st_r == M_DONE)) begin
			cal_alu_nxt = 1'b0;
			cph_nxt = '0;
			st_nxt = M_CAL;
		end
		if (init_p) begin
			ptr_nxt = '0;
			hits_nxt = '0;
			alu_nxt = '0;
			st_nxt = cfg_ok ? M_ARMED : M_IDLE;
		end
	end
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			st_r <= M_IDLE;
			div_r <= '0;
			slow_r <= '0;
			warm_r <= '0;
			coarse_r <= '0;
			last_r <= '0;
			hc_r <= '{default: '0};
			hf_r <= '{default: '0};
			hits_r <= '0;
			ptr_r <= '0;
			one_period_cal_count_r <= '0;
			two_period_cal_count_r <= '0;
			ccnt_r <= '0;
			cph_r <= '0;
			cal_alu_r <= 1'b0;
			alu_r <= '0;
			res_r <= '{default: '0};
		end else begin
			st_r <= st_nxt;
			div_r <= div_nxt;
			slow_r <= slow_nxt;
			warm_r <= warm_nxt;
			coarse_r <= coarse_nxt;
			last_r <= last_nxt;
			hc_r <= hc_nxt;
			hf_r <= hf_nxt;
			hits_r <= hits_nxt;
			ptr_r <= ptr_nxt;
			one_period_cal_count_r <= one_period_cal_count_nxt;
			two_period_cal_count_r <= two_period_cal_count_nxt;
			ccnt_r <= ccnt_nxt;
			cph_r <= cph_nxt;
			cal_alu_r <= cal_alu_nxt;
			alu_r <= alu_nxt;
			res_r <= res_nxt;
		end
	end
endmodule : imr_device

// *** logic/imr_host.sv ***
// Host end: APB-programmed serial command engine that drives the device link.
`timescale 1ns/100ps
module imr_host import imr_pkg::*; (
	input logic clk, // System clock.
	input logic reset_n, // Asynchronous reset, active low.
	input logic [11:0] paddr, // APB address.
	input logic psel, // APB select.
	input logic penable, // APB enable.
	input logic pwrite, // APB direction, high for write.
	input logic [31:0] pwdata, // APB write data.
	output logic [31:0] prdata, // APB read data.
	output logic pready, // APB ready.
	output logic pslverr, // APB error on unmapped address.
	imr_link_if.host link // Serial port toward the device.
);
	imr_host_t st_r, st_nxt;
	logic [1:0] meta_r, sync_r;
	logic [39:0] sr_r, sr_nxt;
	logic [31:0] tx_r, tx_nxt, rx_r, rx_nxt, prdata_r, prdata_nxt;
	logic [7:0] op_r, op_nxt;
	logic [5:0] len_r, len_nxt, bits_r, bits_nxt;
	logic [3:0] half_r, half_nxt;
	logic [8:0] guard_r, guard_nxt;
	logic sck_r, sck_nxt, sel_n_r, sel_n_nxt, mosi_r, mosi_nxt, rearm_r, rearm_nxt;
	logic wr, mapped;

	// Link inputs are asynchronous to clk.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			meta_r <= '1;
			sync_r <= '1;
		end else begin
			meta_r <= {link.irq_out_n, link.miso};
			sync_r <= meta_r;
		end
	end

	assign wr = psel & penable & pwrite;
	assign mapped = paddr == A_CTRL || paddr == A_TX || paddr == A_RX || paddr == A_STAT;
	always_comb begin
		st_nxt = st_r;
		sr_nxt = sr_r;
		tx_nxt = tx_r;
		rx_nxt = rx_r;
		op_nxt = op_r;
		len_nxt = len_r;
		bits_nxt = bits_r;
		half_nxt = half_r;
		guard_nxt = guard_r;
		sck_nxt = sck_r;
		sel_n_nxt = sel_n_r;
		mosi_nxt = mosi_r;
		rearm_nxt = rearm_r;
		prdata_nxt = prdata_r;
		if (psel && !penable) begin
			case (paddr)
				A_CTRL: prdata_nxt = {18'h0, len_r, op_r};
				A_TX: prdata_nxt = tx_r;
				A_RX: prdata_nxt = rx_r;
				A_STAT: prdata_nxt = {29'h0, rearm_r, ~sync_r[1], st_r != H_IDLE};
				default: prdata_nxt = '0;
			endcase
		end
		case (st_r)
			H_IDLE: begin
				if (wr && paddr == A_TX) begin
					tx_nxt = pwdata;
				end
				if (wr && paddr == A_CTRL && pwdata[C_GO]) begin
					op_nxt = pwdata[7:0];
					len_nxt = pwdata[C_LEN_LO +: 6];
					sr_nxt = {pwdata[7:0], tx_r};
					rx_nxt = '0;
					bits_nxt = '0;
					half_nxt = '0;
					sel_n_nxt = 1'b0;
					mosi_nxt = pwdata[7];
					st_nxt = H_LEAD;
				end
			end
			H_LEAD: begin
				half_nxt = half_r + 4'h1;
				if (half_r == SCK_HALF_CYC - 4'h1) begin
					half_nxt = '0;
					st_nxt = H_SHIFT;
				end
			end
			H_SHIFT: begin
				half_nxt = half_r + 4'h1;
				if (half_r == SCK_HALF_CYC - 4'h1) begin
					half_nxt = '0;
					sck_nxt = ~sck_r;
					if (!sck_r) begin
						bits_nxt = bits_r + 6'h01;
						if (bits_r >= BC_OP_BITS) begin
							rx_nxt = {rx_r[30:0], sync_r[0]};
						end
					end else if (bits_r == BC_OP_BITS + len_r) begin
						sel_n_nxt = 1'b1;
						// Selector rewrites need the ALU to finish before the next access.
						guard_nxt = (op_r == (OP_WRITE | 8'(CFG_HIT_ADR))) ? 9'(HIT_WAIT_CYC) : 9'(SCK_HALF_CYC);
						if ((op_r & OP_MASK) == OP_READ && op_r[2:0] < STATUS_ADR) begin
							rearm_nxt = 1'b1;
						end
						if (op_r == OP_INIT) begin
							rearm_nxt = 1'b0;
						end
						st_nxt = H_GUARD;
					end else begin
						sr_nxt = {sr_r[38:0], 1'b0};
						mosi_nxt = sr_r[38];
					end
				end
			end
			H_GUARD: begin
				guard_nxt = guard_r - 9'h001;
				if (guard_r == 9'h001) begin
					st_nxt = H_IDLE;
				end
			end
			default: begin
				st_nxt = H_IDLE;
			end
		endcase
	end
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			st_r <= H_IDLE;
			sr_r <= '0;
			tx_r <= '0;
			rx_r <= '0;
			op_r <= '0;
			len_r <= '0;
			bits_r <= '0;
			half_r <= '0;
			guard_r <= '0;
			sck_r <= 1'b0;
			sel_n_r <= 1'b1;
			mosi_r <= 1'b0;
			rearm_r <= 1'b0;
			prdata_r <= '0;
		end else begin
			st_r <= st_nxt;
			sr_r <= sr_nxt;
			tx_r <= tx_nxt;
			rx_r <= rx_nxt;
			op_r <= op_nxt;
			len_r <= len_nxt;
			bits_r <= bits_nxt;
			half_r <= half_nxt;
			guard_r <= guard_nxt;
			sck_r <= sck_nxt;
			sel_n_r <= sel_n_nxt;
			mosi_r <= mosi_nxt;
			rearm_r <= rearm_nxt;
			prdata_r <= prdata_nxt;
		end
	end
	assign prdata = prdata_r;
	assign pready = psel & penable;
	assign pslverr = psel & penable & ~mapped;
	assign link.sck = sck_r;
	assign link.sel_n = sel_n_r;
	assign link.mosi = mosi_r;
endmodule : imr_host

// *** bench/imr_link_monitor.sv ***
// Protocol checker for the serial link between host and device.
`timescale 1ns/100ps
module imr_link_monitor (
	input logic clk, // System clock.
	input logic reset_n, // Reset, active low.
	input logic sck, // Serial clock.
	input logic sel_n, // Frame select, active low.
	input logic mosi, // Host data.
	input logic miso, // Device data.
	input logic irq_out_n // Interrupt, active low.
);
	logic sck_q_r;
	logic [5:0] rise_r;
	// Counts serial clock rises inside a frame so the frame length can be judged at its end.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			sck_q_r <= 1'b0;
			rise_r <= 6'h00;
		end else begin
			sck_q_r <= sck;
			rise_r <= sel_n ? 6'h00 : rise_r + {5'h00, sck & !sck_q_r};
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	a_sck_idle_low: assert property (sel_n |-> !sck)
		else $error("serial clock active outside frame");
	a_lead_time: assert property ($fell(sel_n) |-> !sck [*8] ##1 !sck [*8] ##1 sck)
		else $error("first clock rise not 16 cycles after select");
	a_sck_high_len: assert property ($rose(sck) |-> sck [*8] ##1 !sck)
		else $error("clock high phase wrong");
	a_sck_low_len: assert property ($fell(sck) |-> !sck [*8])
		else $error("clock low phase too short");
	a_mosi_hold: assert property (sck && $past(sck) |-> $stable(mosi))
		else $error("host data moved while clock high");
	a_frame_bits: assert property ($rose(sel_n) |-> rise_r inside {6'h08, 6'h18, 6'h28})
		else $error("frame bit count wrong");
	a_guard_gap: assert property ($rose(sel_n) |-> sel_n [*8])
		else $error("guard after frame too short");
	a_irq_clear: assert property ($rose(sck) && !irq_out_n |-> ##[1:6] irq_out_n)
		else $error("clock rise did not clear interrupt");
	cover property ($rose(sel_n) && rise_r == 6'h28 && miso);
	cover property ($rose(sel_n) && rise_r == 6'h18);
	cover property ($fell(irq_out_n));
endmodule : imr_link_monitor

// *** bench/interval_measure_readout_bench.sv ***
// Self-checking bench joining host and device ends over the link.
`timescale 1ns/100ps
module interval_measure_readout_bench import imr_pkg::*;;
	logic clk, reset_n, psel, penable, pwrite, pready, pslverr, e;
	logic start_in, stop_in, start_en, stop_en, osc_power_on;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, q;
	int fail_count, tests_run;
	imr_link_if imr_link_if_inst ();
	imr_host imr_host_inst (.clk(clk), .reset_n(reset_n), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .link(imr_link_if_inst.host));
	imr_device imr_device_inst (.clk(clk), .reset_n(reset_n), .link(imr_link_if_inst.dev),
		.start_in(start_in), .stop_in(stop_in), .start_en(start_en), .stop_en(stop_en),
		.osc_power_on(osc_power_on));
	imr_link_monitor imr_link_monitor_inst (.clk(clk), .reset_n(reset_n),
		.sck(imr_link_if_inst.sck), .sel_n(imr_link_if_inst.sel_n),
		.mosi(imr_link_if_inst.mosi), .miso(imr_link_if_inst.miso),
		.irq_out_n(imr_link_if_inst.irq_out_n));
	always #5 clk = ~clk;
	task automatic end_sim;
		$display("checks %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : end_sim
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			fail_count++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (pready !== 1'b1) begin
			fail_count++;
			end_sim();
		end
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic poll(input int b, input logic v);
		int n;
		n = 0;
		do begin
			apb(1'b0, A_STAT, 32'h0000_0000);
			n++;
		end while (q[b] !== v && n < 3000);
		if (q[b] !== v) begin
			fail_count++;
			end_sim();
		end
	endtask : poll
	// Sends one frame and leaves the received word in q.
	task automatic op(input logic [7:0] c, input logic [5:0] len, input logic [31:0] d);
		apb(1'b1, A_TX, d);
		apb(1'b1, A_CTRL, 32'h8000_0000 | {18'h0_0000, len, c});
		poll(0, 1'b0);
		apb(1'b0, A_RX, 32'h0000_0000);
	endtask : op
	task automatic stp(input int gap);
		repeat (gap - 10) @(posedge clk);
		stop_in <= 1'b1;
		repeat (10) @(posedge clk);
		stop_in <= 1'b0;
	endtask : stp
	task automatic hits(input int n, input int gap);
		@(posedge clk);
		start_in <= !start_in;
		repeat (10) @(posedge clk);
		start_in <= !start_in;
		for (int i = 0; i < n; i++) stp(gap);
	endtask : hits
	initial begin
		{clk, reset_n, psel, penable, pwrite, start_in, stop_in} = 7'h00;
		{start_en, stop_en, paddr, pwdata, fail_count, tests_run} = '0;
		start_en = 1'b1;
		stop_en = 1'b1;
		repeat (3) @(posedge clk);
		reset_n <= 1'b1;
		op(OP_WRITE | 8'h00, 6'h20, 32'h0004_2800);
		chk({31'h0000_0000, osc_power_on}, 32'h0000_0001);
		op(OP_WRITE | 8'h02, 6'h20, 32'h2000_0000);
		op(OP_WRITE | 8'h01, 6'h20, 32'h1204_0000);
		op(OP_INIT, 6'h00, 32'h0000_0000);
		hits(3, 100);
		for (int i = 0; i < 3; i++) begin
			poll(1, 1'b1);
			op(OP_READ | i[7:0], 6'h20, 32'h0000_0000);
			chk(q, 32'h0004_0000 * (i + 1));
			if (i < 2) op(OP_WRITE | 8'h01, 6'h20, 32'h1204_0000 + 32'h0100_0000 * (i + 1));
		end
		op(OP_READ | 8'h04, 6'h10, 32'h0000_0000);
		chk(q & 32'h0000_003F, 32'h0000_0023);
		$display("test three hits done");
		hits(1, 100);
		repeat (700) @(posedge clk);
		apb(1'b0, A_STAT, 32'h0000_0000);
		chk(q & 32'h0000_0006, 32'h0000_0004);
		op(OP_READ | 8'h04, 6'h10, 32'h0000_0000);
		chk(q & 32'h0000_003F, 32'h0000_0023);
		$display("test rearm done");
		start_in <= 1'b1;
		op(OP_WRITE | 8'h00, 6'h20, 32'h0014_2801);
		op(OP_WRITE | 8'h01, 6'h20, 32'h1202_0000);
		op(OP_INIT, 6'h00, 32'h0000_0000);
		hits(1, 40);
		stop_en <= 1'b0;
		stp(60);
		stop_en <= 1'b1;
		stp(200);
		poll(1, 1'b1);
		op(OP_READ, 6'h20, 32'h0000_0000);
		chk(q, 32'h0006_0000);
		op(OP_WRITE | 8'h01, 6'h20, 32'h1302_0000);
		poll(1, 1'b1);
		op(OP_READ | 8'h01, 6'h20, 32'h0000_0000);
		chk(q, ALL_ONES);
		op(OP_WRITE | 8'h00, 6'h20, 32'h0014_0801);
		op(OP_WRITE | 8'h01, 6'h20, 32'h1202_0000);
		poll(1, 1'b1);
		op(OP_READ | 8'h02, 6'h10, 32'h0000_0000);
		chk(q & 32'h0000_FFFF, 32'h0000_012C);
		op(OP_CAL, 6'h00, 32'h0000_0000);
		repeat (200) @(posedge clk);
		op(OP_READ | 8'h04, 6'h10, 32'h0000_0000);
		chk(q & 32'h0000_01C0, 32'h0000_0000);
		$display("test formats done");
		apb(1'b0, 12'h010, 32'h0000_0000);
		chk({31'h0000_0000, e}, 32'h0000_0001);
		chk(q, 32'h0000_0000);
		$display("test unmapped done");
		end_sim();
	end
endmodule : interval_measure_readout_bench
